/* File: pkg/hcp_pkg.sv */
// constants shared by both ends of the host control port
//
// Contract
// - port reaches all registers; spi or i2c
// - host spi clock at most 25 MHz
// - host i2c clock at most 400 kHz
// - stopped serial clock loses no data
// - every sixteen clocks hand over a word
// - first output bit after later falling edge
// - select high at least 61 ns
// - command framing: words back to back
// - reset unless low 8 or 16 clocks
// - byte/word framing: several commands per select
// - select rising edge ends sequence, resets
// - serial output released after select rises
// - host samples either edge, matching setup
// - i2c shares the spi pins
// - i2c inputs ignore spikes up to 50 ns
package hcp_pkg;

  // ****************************************
  // framing
  // ****************************************
  localparam int WORD_BITS = 16; // one spi word
  localparam int BYTE_BITS = 8; // one spi byte, one i2c byte
  localparam logic [3:0] LAST_BIT = 4'hF; // index of sixteenth bit
  localparam logic [3:0] BYTE_LAST = 4'h7; // index of eighth bit
  localparam logic [3:0] OVER_BIT = 4'h8; // ninth bit, frame is no byte
  localparam logic [3:0] I2C_ACK_AT = 4'h8; // bits before an acknowledge

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_NS = 50; // system clock period
  localparam int SCLK_MIN_NS = 40; // fastest spi serial clock period
  localparam int I2C_MAX_KHZ = 400; // fastest i2c clock
  localparam int CS_GAP_NS = 61; // least select-high time
  localparam int SPIKE_NS = 50; // widest spike to suppress
  // least half period of the host serial clock, rounded up
  localparam int HOST_HALF_MIN_CYC = (SCLK_MIN_NS + 2 * SYS_CLK_NS - 1) / (2 * SYS_CLK_NS);
  // default half period: leaves room for the two-stage input sampler
  localparam int HOST_HALF_CYC = 4;
  // select-high gap in cycles, rounded up
  localparam int CS_GAP_CYC = (CS_GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  // samples a level must hold before the filter passes it
  localparam int FILT_CYC = (SPIKE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS + 2;
  localparam logic FILT_RST = 1'b1; // idle bus level

endpackage : hcp_pkg

/* File: pkg/hcp_if.sv */
// pin bundle between host and device ends of the host control port
`timescale 1ns/1ps
interface hcp_if;
  logic host_sclk; // serial clock, i2c clock as well; made by the host
  logic host_slave_select_n; // slave select, active low
  logic host_hsi_o; // host drive onto the serial-in pin
  logic host_hsi_oe_n; // host enable on the serial-in pin, low drives
  logic dev_sda_oe_n; // device pull-down on serial-in pin (i2c data)
  logic dev_hso_o; // device drive onto the serial-out pin
  logic dev_hso_oe_n; // device enable on the serial-out pin, low drives
  logic host_serial_in; // resolved level of the serial-in pin
  logic host_serial_out; // resolved level of the serial-out pin

  // wired-and with a pull-up: a device pull-down always wins
  assign host_serial_in = !dev_sda_oe_n ? 1'b0 : (!host_hsi_oe_n ? host_hsi_o : 1'b1);
  // released output floats high through the pull-up
  assign host_serial_out = !dev_hso_oe_n ? dev_hso_o : 1'b1;

  modport dev (
    input host_sclk, host_slave_select_n, host_serial_in,
    output dev_sda_oe_n, dev_hso_o, dev_hso_oe_n
  );
  modport host (
    output host_sclk, host_slave_select_n, host_hsi_o, host_hsi_oe_n,
    input host_serial_out
  );
endinterface : hcp_if

/* File: logic/hcp_glitch_filter.sv */
// spike filter with two-stage input sampler, one lane per bit
`timescale 1ns/1ps
module hcp_glitch_filter
  import hcp_pkg::*;
#(
  parameter int WIDTH = 2, // number of lanes
  parameter int STABLE = FILT_CYC // samples a new level must hold
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  localparam int CW = $clog2(STABLE + 1); // counter width

  // ****************************************
  // per-lane filter
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic s1_q, s2_q; // sampler stages; s1 feeds s2 only
      logic [CW-1:0] cnt_q, cnt_d; // samples seen at the new level
      logic out_q, out_d; // filtered level
      // count while the input differs; a spike restarts the count
      always_comb begin
        cnt_d = '0;
        out_d = out_q;
        if (s2_q != out_q) begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CW'(STABLE - 1)) begin
            out_d = s2_q;
            cnt_d = '0;
          end
        end
      end
      // registers only
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          s1_q <= FILT_RST;
          s2_q <= FILT_RST;
          cnt_q <= '0;
          out_q <= FILT_RST;
        end else begin
          s1_q <= din[g];
          s2_q <= s1_q;
          cnt_q <= cnt_d;
          out_q <= out_d;
        end
      end
      assign dout[g] = out_q;
    end
  endgenerate
endmodule : hcp_glitch_filter

/* File: logic/hcp_device.sv */
// device end of the host control port: spi slave and i2c slave
`timescale 1ns/1ps
module hcp_device
  import hcp_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR = 7'h2A // bus address, value arbitrary
) (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  input wire logic i2c_sel, // port configuration, 1 selects i2c
  input wire logic [WORD_BITS-1:0] tx_word, // next word to send
  input wire logic tx_load, // strobe for tx_word
  output logic [WORD_BITS-1:0] rx_data, // received word or byte
  output logic rx_valid, // one-cycle strobe for rx_data
  output logic rx_is_byte, // rx_data holds a byte in its low half
  output logic frame_end, // one-cycle strobe: select rose / i2c stop
  output logic len_err, // one-cycle strobe: frame ended 9 to 15 bits past its last word
  hcp_if.dev link
);

  // ****************************************
  // link domain: spi receive on serial clock
  // ****************************************
  logic link_rst; // global reset or select high
  logic [3:0] bit_cnt_q, bit_cnt_d; // bits in current word
  logic [WORD_BITS-1:0] shift_q, shift_d; // receive shifter
  logic [WORD_BITS-1:0] word_q, word_d; // last full word, held for sys
  logic [BYTE_BITS-1:0] byte_q, byte_d; // first byte of the word
  logic word_t_q, word_t_d; // toggles per word
  logic byte_t_q, byte_t_d; // toggles per eighth bit
  logic over_t_q, over_t_d; // toggles per ninth bit
  logic fell_q; // a falling edge has been seen this frame
  logic out_q, out_d; // serial output bit
  logic [WORD_BITS-1:0] tx_hold_q, tx_hold_d; // word to send, sys owned

  // select high clears the frame logic
  assign link_rst = reset | link.host_slave_select_n;

  // next values of the frame shifter and data holders
  always_comb begin
    bit_cnt_d = bit_cnt_q + 4'h1;
    // msb first, sampled on rising edge
    shift_d = {shift_q[WORD_BITS-2:0], link.host_serial_in};
    word_d = word_q;
    byte_d = byte_q;
    word_t_d = word_t_q;
    byte_t_d = byte_t_q;
    over_t_d = over_t_q;
    if (bit_cnt_q == LAST_BIT) begin
      word_d = shift_d;
      word_t_d = ~word_t_q;
    end
    // byte boundary, kept for byte framing
    if (bit_cnt_q == BYTE_LAST) begin
      byte_d = shift_d[BYTE_BITS-1:0];
      byte_t_d = ~byte_t_q;
    end
    // ninth bit: frame is no longer a byte
    if (bit_cnt_q == OVER_BIT) begin
      over_t_d = ~over_t_q;
    end
  end

  // frame state, cleared at every select rise
  always_ff @(posedge link.host_sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 4'h0;
      shift_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
    end
  end

  // only edges move these; a stopped clock keeps them
  always_ff @(posedge link.host_sclk or posedge reset) begin
    if (reset) begin
      word_q <= '0;
      byte_q <= '0;
      word_t_q <= 1'b0;
      byte_t_q <= 1'b0;
      over_t_q <= 1'b0;
    end else begin
      word_q <= word_d;
      byte_q <= byte_d;
      word_t_q <= word_t_d;
      byte_t_q <= byte_t_d;
      over_t_q <= over_t_d;
    end
  end

  // ****************************************
  // link domain: spi transmit on falling edge
  // ****************************************
  // tx_hold only changes between words, so it is quiet when sampled
  always_comb begin
    out_d = tx_hold_q[~bit_cnt_q];
  end

  // output shifter on falling edges
  always_ff @(negedge link.host_sclk or posedge link_rst) begin
    if (link_rst) begin
      fell_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      fell_q <= 1'b1;
      out_q <= out_d;
    end
  end

  // msb shows from select fall until the first falling edge
  assign link.dev_hso_o = fell_q ? out_q : tx_hold_q[WORD_BITS-1];
  // released as soon as select rises
  // spi output idles while i2c owns the pins
  assign link.dev_hso_oe_n = link.host_slave_select_n | i2c_sel;

  // ****************************************
  // system domain: crossing from the link
  // ****************************************
  logic [3:0] sync1_q, sync2_q, sync3_q; // {over, byte, word, select}
  logic [2:0] ev; // toggle events {over, byte, word}
  logic cs_rise; // select rose

  // sampler chain; stage one is read by stage two only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_q <= 4'h1;
      sync2_q <= 4'h1;
      sync3_q <= 4'h1;
    end else begin
      sync1_q <= {over_t_q, byte_t_q, word_t_q, link.host_slave_select_n};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign ev = sync2_q[3:1] ^ sync3_q[3:1];
  assign cs_rise = sync2_q[0] & ~sync3_q[0];

  // ****************************************
  // system domain: i2c slave
  // ****************************************
  // address phase is I2C_HDR so it cannot clash with the bus address parameter
  typedef enum logic [2:0] {I2C_IDLE, I2C_HDR, I2C_DATA, I2C_ACK, I2C_SKIP} hcp_i2c_t;
  hcp_i2c_t ist_q, ist_d; // i2c state
  logic [1:0] filt; // {scl, sda} after spike filter
  logic scl_p_q, sda_p_q; // previous filtered levels
  logic [3:0] ibit_q, ibit_d; // i2c bit count
  logic [BYTE_BITS-1:0] ish_q, ish_d; // i2c shifter
  logic start_c, stop_c, scl_rise, scl_fall; // bus events

  // both i2c inputs go through the spike filter
  hcp_glitch_filter #(.WIDTH(2), .STABLE(FILT_CYC)) u_filt (
    .clock(clock),
    .reset(reset),
    .din({link.host_sclk, link.host_serial_in}),
    .dout(filt)
  );
  assign start_c = filt[1] & scl_p_q & sda_p_q & ~filt[0];
  assign stop_c = filt[1] & scl_p_q & ~sda_p_q & filt[0];
  assign scl_rise = filt[1] & ~scl_p_q;
  assign scl_fall = ~filt[1] & scl_p_q;
  // i2c acknowledge pulls the shared serial-in pin low
  assign link.dev_sda_oe_n = ~(i2c_sel & (ist_q == I2C_ACK));

  // ****************************************
  // system domain: delivery to the user
  // ****************************************
  logic [WORD_BITS-1:0] rx_data_q, rx_data_d; // delivered data
  logic valid_q, valid_d, is_byte_q, is_byte_d; // delivery flags
  logic fend_q, fend_d, lerr_q, lerr_d; // frame strobes
  logic pend_q, pend_d; // byte seen, may end the frame
  logic mid_q, mid_d; // bits beyond a byte, word unfinished

  // next values of delivery and i2c state
  always_comb begin
    rx_data_d = rx_data_q;
    valid_d = 1'b0;
    is_byte_d = is_byte_q;
    fend_d = 1'b0;
    lerr_d = 1'b0;
    pend_d = pend_q;
    mid_d = mid_q;
    ist_d = ist_q;
    ibit_d = ibit_q;
    ish_d = ish_q;
    tx_hold_d = tx_load ? tx_word : tx_hold_q;
    // configuration picks which slave serves the user
    if (!i2c_sel) begin
      if (ev[1]) pend_d = 1'b1;
      if (ev[2]) begin
        pend_d = 1'b0;
        mid_d = 1'b1;
      end
      if (ev[0]) begin
        rx_data_d = word_q;
        is_byte_d = 1'b0;
        valid_d = 1'b1;
        pend_d = 1'b0;
        mid_d = 1'b0;
      end
      // frame may carry many commands until select rises
      if (cs_rise) begin
        fend_d = 1'b1;
        if (pend_d) begin
          rx_data_d = {{(WORD_BITS-BYTE_BITS){1'b0}}, byte_q};
          is_byte_d = 1'b1;
          valid_d = 1'b1;
        end else if (mid_d) begin
          // 9 to 15 bits past the last word: flagged and dropped
          lerr_d = 1'b1;
        end
        pend_d = 1'b0;
        mid_d = 1'b0;
      end
    end else begin
      // rising clock samples data in address and data phases
      if (scl_rise && (ist_q == I2C_HDR || ist_q == I2C_DATA)) begin
        ish_d = {ish_q[BYTE_BITS-2:0], filt[0]};
        ibit_d = ibit_q + 4'h1;
      end
      if (scl_fall) begin
        case (ist_q)
          I2C_HDR: begin
            // only a write to our address is acknowledged
            if (ibit_q == I2C_ACK_AT) begin
              ist_d = (ish_q == {I2C_ADDR, 1'b0}) ? I2C_ACK : I2C_SKIP;
            end
          end
          I2C_DATA: begin
            if (ibit_q == I2C_ACK_AT) begin
              rx_data_d = {{(WORD_BITS-BYTE_BITS){1'b0}}, ish_q};
              is_byte_d = 1'b1;
              valid_d = 1'b1;
              ist_d = I2C_ACK;
            end
          end
          I2C_ACK: begin
            ist_d = I2C_DATA;
            ibit_d = 4'h0;
          end
          default: ist_d = ist_q;
        endcase
      end
      if (start_c) begin
        ist_d = I2C_HDR;
        ibit_d = 4'h0;
      end
      if (stop_c) begin
        ist_d = I2C_IDLE;
        fend_d = 1'b1;
      end
    end
  end

  // registers of the system domain
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_data_q <= '0;
      valid_q <= 1'b0;
      is_byte_q <= 1'b0;
      fend_q <= 1'b0;
      lerr_q <= 1'b0;
      pend_q <= 1'b0;
      mid_q <= 1'b0;
      ist_q <= I2C_IDLE;
      ibit_q <= 4'h0;
      ish_q <= '0;
      scl_p_q <= FILT_RST;
      sda_p_q <= FILT_RST;
      tx_hold_q <= '0;
    end else begin
      rx_data_q <= rx_data_d;
      valid_q <= valid_d;
      is_byte_q <= is_byte_d;
      fend_q <= fend_d;
      lerr_q <= lerr_d;
      pend_q <= pend_d;
      mid_q <= mid_d;
      ist_q <= ist_d;
      ibit_q <= ibit_d;
      ish_q <= ish_d;
      scl_p_q <= filt[1];
      sda_p_q <= filt[0];
      tx_hold_q <= tx_hold_d;
    end
  end

  assign rx_data = rx_data_q;
  assign rx_valid = valid_q;
  assign rx_is_byte = is_byte_q;
  assign frame_end = fend_q;
  assign len_err = lerr_q;
endmodule : hcp_device

/* File: logic/hcp_host.sv */
// host end of the host control port: spi master with divided clock
`timescale 1ns/1ps
module hcp_host
  import hcp_pkg::*;
#(
  parameter int HALF = HOST_HALF_CYC // half serial period in cycles
) (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  input wire logic start, // begin a command, taken while idle
  input wire logic [7:0] n_words, // words or bytes in command, 0 as 1
  input wire logic byte_mode, // 8-bit units instead of 16
  input wire logic [WORD_BITS-1:0] tx_word, // unit to send
  output logic tx_take, // strobe: tx_word consumed
  output logic [WORD_BITS-1:0] rx_word, // received unit
  output logic rx_valid, // strobe for rx_word
  output logic busy, // command in progress
  hcp_if.host link
);
  localparam int DW = $clog2(HALF + CS_GAP_CYC + 1); // divider width

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} hcp_hst_t;
  hcp_hst_t st_q, st_d; // master state
  logic [DW-1:0] div_q, div_d; // phase counter
  logic [3:0] bit_q, bit_d; // bit in unit
  logic [7:0] rem_q, rem_d; // units still to send
  logic [WORD_BITS-1:0] sh_q, sh_d, rx_q, rx_d, rxw_q, rxw_d; // shifters
  logic sclk_q, sclk_d, cs_n_q, cs_n_d, take_q, take_d, rv_q, rv_d;
  logic so1_q, so2_q; // serial-out sampler; so1 feeds so2 only

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    div_d = div_q + 1'b1;
    bit_d = bit_q;
    rem_d = rem_q;
    sh_d = sh_q;
    rx_d = rx_q;
    rxw_d = rxw_q;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    take_d = 1'b0;
    rv_d = 1'b0;
    case (st_q)
      H_IDLE: begin
        div_d = '0;
        if (start) begin
          cs_n_d = 1'b0;
          sh_d = byte_mode ? {tx_word[BYTE_BITS-1:0], 8'h00} : tx_word;
          take_d = 1'b1;
          bit_d = 4'h0;
          rem_d = (n_words == 8'h00) ? 8'h00 : n_words - 8'h01;
          st_d = H_LOW;
        end
      end
      H_LOW: begin
        // a half period from select fall to first rise
        if (div_q == DW'(HALF - 1)) begin
          // divided clock never faster than allowed
          sclk_d = 1'b1;
          div_d = '0;
          st_d = H_HIGH;
        end
      end
      H_HIGH: begin
        if (div_q == DW'(HALF - 1)) begin
          // sample late in the high phase, sampler settled
          rx_d = {rx_q[WORD_BITS-2:0], so2_q};
          sh_d = {sh_q[WORD_BITS-2:0], 1'b0};
          sclk_d = 1'b0;
          div_d = '0;
          bit_d = bit_q + 4'h1;
          st_d = H_LOW;
          if (bit_q == (byte_mode ? BYTE_LAST : LAST_BIT)) begin
            rxw_d = byte_mode ? {8'h00, rx_d[BYTE_BITS-1:0]} : rx_d;
            rv_d = 1'b1;
            bit_d = 4'h0;
            if (rem_q == 8'h00) begin
              cs_n_d = 1'b1;
              st_d = H_GAP;
            end else begin
              // next unit follows with select still low
              // many commands in one select period
              rem_d = rem_q - 8'h01;
              sh_d = byte_mode ? {tx_word[BYTE_BITS-1:0], 8'h00} : tx_word;
              take_d = 1'b1;
            end
          end
        end
      end
      H_GAP: begin
        if (div_q == DW'(CS_GAP_CYC - 1)) st_d = H_IDLE;
      end
      default: st_d = H_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= H_IDLE;
      div_q <= '0;
      bit_q <= 4'h0;
      rem_q <= 8'h00;
      sh_q <= '0;
      rx_q <= '0;
      rxw_q <= '0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      take_q <= 1'b0;
      rv_q <= 1'b0;
      so1_q <= 1'b1;
      so2_q <= 1'b1;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      bit_q <= bit_d;
      rem_q <= rem_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      rxw_q <= rxw_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      take_q <= take_d;
      rv_q <= rv_d;
      so1_q <= link.host_serial_out;
      so2_q <= so1_q;
    end
  end

  // ****************************************
  // pins and user outputs
  // ****************************************
  assign link.host_sclk = sclk_q;
  assign link.host_slave_select_n = cs_n_q;
  assign link.host_hsi_o = sh_q[WORD_BITS-1];
  // no i2c master here, so the i2c clock limit holds trivially
  assign link.host_hsi_oe_n = 1'b0;
  assign tx_take = take_q;
  assign rx_word = rxw_q;
  assign rx_valid = rv_q;
  assign busy = (st_q != H_IDLE);
endmodule : hcp_host

/* File: verif/hcp_link_props.sv */
// pin-level checks between host and device ends
`timescale 1ns/1ps
module hcp_link_props
  import hcp_pkg::*;
#(
  parameter int HALF = HOST_HALF_CYC // host half period
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic i2c_sel,
  input wire logic host_sclk,
  input wire logic host_slave_select_n,
  input wire logic host_hsi_o,
  input wire logic dev_hso_o,
  input wire logic dev_hso_oe_n
);
  // ****************************************
  // helper counters
  // ****************************************
  logic [7:0] high_q; // high cycles of this clock phase
  logic [7:0] high_d;
  logic [11:0] frame_q; // high cycles within this select period
  logic [11:0] frame_d;
  // next values; both clear when their window closes
  always_comb begin
    high_d = host_sclk ? high_q + 8'h01 : 8'h00;
    frame_d = host_slave_select_n ? 12'h000 : frame_q + {11'h000, host_sclk};
  end
  // registers only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      high_q <= 8'h00;
      frame_q <= 12'h000;
    end else begin
      high_q <= high_d;
      frame_q <= frame_d;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // select fall leaves a full low phase before the first rise
  sequence s_lead; !host_sclk [*4] ##1 host_sclk; endsequence
  property p_lead; $fell(host_slave_select_n) |-> s_lead; endproperty
  a_lead: assert property (p_lead) else $error("lead-in wrong");
  property p_gap; $rose(host_slave_select_n) |-> host_slave_select_n [*2]; endproperty
  a_gap: assert property (p_gap) else $error("select gap short");
  property p_half; $fell(host_sclk) |-> int'(high_q) == HALF; endproperty
  a_half: assert property (p_half) else $error("high phase length");
  // whole bytes only, so the device never sees an odd length
  property p_frame;
    $rose(host_slave_select_n) |-> frame_q != 0 && int'(frame_q) % (8 * HALF) == 0;
  endproperty
  a_frame: assert property (p_frame) else $error("frame length odd");
  property p_in_frame; $rose(host_sclk) |-> !host_slave_select_n; endproperty
  a_in_frame: assert property (p_in_frame) else $error("clock outside frame");
  property p_release; host_slave_select_n |-> dev_hso_oe_n; endproperty
  a_release: assert property (p_release) else $error("output not released");
  property p_drive; !host_slave_select_n && !i2c_sel |-> !dev_hso_oe_n; endproperty
  a_drive: assert property (p_drive) else $error("output not driven");
  // the spi output stands aside whenever i2c owns the pins
  property p_idle; i2c_sel |-> dev_hso_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("spi output on in i2c mode");
  // output moves only after a falling edge, never in the high phase
  property p_hold;
    !host_slave_select_n && host_sclk && $past(host_sclk) |-> $stable(dev_hso_o);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved high");
  property p_shift;
    !host_slave_select_n && !$past(host_slave_select_n) && $changed(host_hsi_o)
      |-> $fell(host_sclk);
  endproperty
  a_shift: assert property (p_shift) else $error("input moved off edge");
endmodule : hcp_link_props

/* File: verif/test_host_control_port_spi_i2c.sv */
// bench joining host and device ends, with a bit-queue model
`timescale 1ns/1ps
module test_host_control_port_spi_i2c import hcp_pkg::*; ;
  logic clock, reset, start, byte_mode, h_take, h_rxv, busy; // host side
  logic d_load, d_rxv, d_isb, frame_end, len_err, i2c_sel; // device side
  logic [7:0] n_words;
  logic [15:0] h_tx, h_rx, d_tx, d_rx, exp_h;
  int mismatches, check_count, seed, fe_n, hv_n, i;
  logic [15:0] unit_q[$]; // host units still to send
  logic [15:0] exp_q[$]; // model: deliveries due at device
  logic expb_q[$]; // model: delivery is a byte
  hcp_if link_i();
  hcp_host #(.HALF(HOST_HALF_CYC)) hcp_host_i (.clock(clock), .reset(reset),
    .start(start), .n_words(n_words), .byte_mode(byte_mode), .tx_word(h_tx),
    .tx_take(h_take), .rx_word(h_rx), .rx_valid(h_rxv), .busy(busy), .link(link_i));
  // no i2c master here: i2c mode only checks that the spi side stands aside
  hcp_device hcp_device_i (.clock(clock), .reset(reset), .i2c_sel(i2c_sel),
    .tx_word(d_tx), .tx_load(d_load), .rx_data(d_rx), .rx_valid(d_rxv),
    .rx_is_byte(d_isb), .frame_end(frame_end), .len_err(len_err), .link(link_i));
  hcp_link_props #(.HALF(HOST_HALF_CYC)) hcp_link_props_i (.clock(clock),
    .reset(reset), .i2c_sel(i2c_sel), .host_sclk(link_i.host_sclk),
    .host_slave_select_n(link_i.host_slave_select_n), .host_hsi_o(link_i.host_hsi_o),
    .dev_hso_o(link_i.dev_hso_o), .dev_hso_oe_n(link_i.dev_hso_oe_n));
  // ****************************************
  // compare and report
  // ****************************************
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // ****************************************
  // monitor: results against the model
  // ****************************************
  always @(posedge clock) begin
    if (d_rxv === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_flag(1'b1, 1'b0);
      end else begin
        cmp_word(d_rx, exp_q.pop_front());
        cmp_flag(d_isb, expb_q.pop_front());
      end
    end
    // only the first unit of a frame is checked against the loaded word
    if (h_rxv === 1'b1) begin
      if (hv_n == 0) cmp_word(byte_mode ? {8'h00, h_rx[7:0]} : h_rx, exp_h);
      hv_n++;
    end
    if (frame_end === 1'b1) fe_n++;
    if (len_err !== 1'b0) cmp_flag(len_err, 1'b0);
    // next unit goes up well before the next boundary
    if (h_take === 1'b1 && unit_q.size() > 0) begin
      void'(unit_q.pop_front());
      h_tx <= #2 (unit_q.size() > 0) ? unit_q[0] : 16'h0000;
    end
  end
  task automatic step();
    @(posedge clock);
    #2;
  endtask : step
  // one select period; model turns units into a bit stream
  task automatic run_frame(input logic bm, input logic [7:0] n);
    logic bitq[$];
    logic [15:0] w;
    int k;
    step();
    d_tx = $random(seed);
    d_load = 1'b1;
    // in i2c mode the released output floats high
    exp_h = i2c_sel ? (bm ? 16'h00FF : 16'hFFFF) : (bm ? {8'h00, d_tx[15:8]} : d_tx);
    for (k = 0; k < ((n == 0) ? 1 : n); k++) begin
      w = $random(seed);
      unit_q.push_back(w);
      for (int b = (bm ? 7 : 15); b >= 0; b--) bitq.push_back(w[b]);
    end
    // words back to back; nothing delivered in i2c mode
    while (!i2c_sel && bitq.size() >= 8) begin
      w = 16'h0000;
      repeat ((bitq.size() >= 16) ? 16 : 8) w = {w[14:0], bitq.pop_front()};
      expb_q.push_back(bitq.size() == 0 && exp_q.size() * 16 + 8 == ((n == 0) ? 1 : n)
        * (bm ? 8 : 16));
      exp_q.push_back(w);
    end
    h_tx = unit_q[0];
    byte_mode = bm;
    n_words = n;
    hv_n = 0;
    fe_n = 0;
    step();
    d_load = 1'b0;
    start = 1'b1;
    step();
    start = 1'b0;
    for (k = 0; k < 5000 && busy !== 1'b0; k++) @(posedge clock);
    if (busy !== 1'b0) begin
      mismatches++;
      give_verdict();
    end
    repeat (8) @(posedge clock);
    cmp_word(16'(fe_n), {15'h0000, ~i2c_sel});
    cmp_word(16'(exp_q.size()), 16'h0000);
    cmp_word(16'(hv_n), (n == 0) ? 16'h0001 : {8'h00, n});
  endtask : run_frame
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    {start, byte_mode, d_load, n_words, h_tx, d_tx, exp_h, i2c_sel} = '0;
    {mismatches, check_count, fe_n, hv_n} = '0;
    seed = 69;
    reset = 1'b1;
    repeat (3) @(posedge clock);
    #2 reset = 0;
    // word and byte mode, one to three units, zero as one
    for (i = 0; i < 8; i++) run_frame(i[0], 8'(i / 2));
    // second reset mid-run, then traffic again
    step();
    reset = 1'b1;
    repeat (3) @(posedge clock);
    #2 reset = 0;
    run_frame(1'b0, 8'h02);
    // i2c configuration: spi output released, no delivery, no frame end
    step();
    i2c_sel = 1'b1;
    run_frame(1'b0, 8'h01);
    run_frame(1'b1, 8'h00);
    give_verdict();
  end
endmodule : test_host_control_port_spi_i2c
